// [bench/agsc_dmem_model.sv]
// data memory model standing behind the address generation block
// assumes responses are valid for one core clock cycle
`timescale 1ns/100ps
module agsc_dmem_model
(
   input wire logic core_clk_i,
   input wire agsc_pkg::agsc_rsp_t rsp_i
);
   // small window only: the bench's stack sits near the floor
   logic [15:0] mem [0:255];
   always @(posedge core_clk_i)
      if (rsp_i.valid && rsp_i.mem_we && !rsp_i.sec_err)
         mem[rsp_i.dst_ea[8:1]] <= rsp_i.mem_wdata;
endmodule // agsc_dmem_model

// [bench/agsc_top_chk.sv]
// stack pointer and stack trap assertions
// assumes bind to agsc_top; one clock domain
`timescale 1ns/100ps
module agsc_top_chk
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire agsc_pkg::agsc_req_t req_i,
   input wire logic reg_we_i,
   input wire logic [3:0] reg_waddr_i,
   input wire logic stack_limit_reg_we_i,
   input wire logic [15:0] stack_limit_reg_wdata_i,
   input wire agsc_pkg::agsc_rsp_t rsp_o,
   input wire logic [15:0] stack_pointer_o,
   input wire logic [15:0] stack_limit_o,
   input wire logic stack_trap_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   logic stk;
   logic push;
   logic pop;
   logic call;
   logic [6:0] pc_hi;
   // a same-cycle pointer write is overridden by the stack step in agsc_top; such cycles are left out
   assign stk = req_i.valid && req_i.iclass == agsc_pkg::IC_STACK
      && !(reg_we_i && reg_waddr_i == agsc_pkg::SP_IDX);
   assign push = stk && req_i.stk == agsc_pkg::SO_PUSH;
   assign pop = stk && req_i.stk == agsc_pkg::SO_POP;
   assign call = stk && req_i.stk == agsc_pkg::SO_CALL;
   assign pc_hi = req_i.pc[22:16];
   chk_push_addr: assert property (push |=> rsp_o.mem_we && rsp_o.dst_ea == $past(stack_pointer_o))
      else $error("push address wrong");
   chk_push_grow: assert property (push |=> stack_trap_o ||
      stack_pointer_o == $past(stack_pointer_o) + 16'h2) else $error("push step wrong");
   chk_pop_first: assert property (pop |=> stack_trap_o ||
      (stack_pointer_o == $past(stack_pointer_o) - 16'h2 && rsp_o.src_ea == stack_pointer_o))
      else $error("pop order wrong");
   chk_limit_equal: assert property (push && stack_pointer_o == stack_limit_o &&
      stack_pointer_o >= agsc_pkg::STACK_FLOOR |=> !stack_trap_o) else $error("trap at limit");
   chk_limit_over: assert property (push && stack_pointer_o > stack_limit_o |=> stack_trap_o)
      else $error("no trap past limit");
   chk_floor_trap: assert property (push && stack_pointer_o < agsc_pkg::STACK_FLOOR |=> stack_trap_o)
      else $error("no underflow trap");
   chk_trap_quiet: assert property (!req_i.valid |=> !stack_trap_o)
      else $error("trap without request");
   chk_limit_align: assert property (stack_limit_reg_we_i |=>
      stack_limit_o == ($past(stack_limit_reg_wdata_i) & 16'hfffe)) else $error("limit bit zero set");
   chk_call_word: assert property (call |=> rsp_o.mem_wdata == {9'h0, $past(pc_hi)})
      else $error("call word wrong");
endmodule // agsc_top_chk
bind agsc_top agsc_top_chk i_agsc_top_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .req_i(req_i), .reg_we_i(reg_we_i), .reg_waddr_i(reg_waddr_i), .stack_limit_reg_we_i(stack_limit_reg_we_i),
   .stack_limit_reg_wdata_i(stack_limit_reg_wdata_i), .rsp_o(rsp_o), .stack_pointer_o(stack_pointer_o),
   .stack_limit_o(stack_limit_o), .stack_trap_o(stack_trap_o));

// [bench/agsc_top_tb.sv]
// self-checking bench for the address generation and stack check block
// assumes responses one cycle after each request
`timescale 1ns/100ps
module agsc_top_tb;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   agsc_pkg::agsc_req_t req_i = '0;
   agsc_pkg::agsc_req_t q;
   logic reg_we_i = 1'b0;
   logic [3:0] reg_waddr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0;
   logic stack_limit_reg_we_i = 1'b0;
   logic [15:0] stack_limit_reg_wdata_i = 16'h0;
   // boot enable, secure enable, running boot, running secure
   logic [3:0] prot = 4'h0;
   agsc_pkg::agsc_rsp_t rsp_o;
   logic [15:0] stack_pointer_o;
   logic [15:0] stack_limit_o;
   logic stack_trap_o;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   agsc_top i_agsc_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
      .reg_we_i(reg_we_i), .reg_waddr_i(reg_waddr_i), .reg_wdata_i(reg_wdata_i),
      .stack_limit_reg_we_i(stack_limit_reg_we_i), .stack_limit_reg_wdata_i(stack_limit_reg_wdata_i), .boot_prot_en_i(prot[3]),
      .sec_prot_en_i(prot[2]), .exec_boot_i(prot[1]), .exec_sec_i(prot[0]), .rsp_o(rsp_o),
      .stack_pointer_o(stack_pointer_o), .stack_limit_o(stack_limit_o),
      .stack_trap_o(stack_trap_o));
   agsc_dmem_model i_agsc_dmem_model (.core_clk_i(core_clk_i), .rsp_i(rsp_o));
   task automatic ck(input logic [15:0] g, input logic [15:0] e, input string m);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic cb(input logic g, input logic e, input string m);
      ck({15'h0, g}, {15'h0, e}, m);
   endtask
   task automatic send(input agsc_pkg::agsc_req_t r);
      r.valid = 1'b1;
      @(posedge core_clk_i);
      #1 req_i = r;
      @(posedge core_clk_i);
      #1 req_i = '0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      #1 reg_we_i = 1'b1;
      reg_waddr_i = a;
      reg_wdata_i = d;
      @(posedge core_clk_i);
      #1 reg_we_i = 1'b0;
   endtask
   task automatic wl(input logic [15:0] d);
      @(posedge core_clk_i);
      #1 stack_limit_reg_we_i = 1'b1;
      stack_limit_reg_wdata_i = d;
      @(posedge core_clk_i);
      #1 stack_limit_reg_we_i = 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic t_stack();
      int i;
      wl(16'h0803);
      ck(stack_limit_o, 16'h0802, "limit lsb");
      q = '0;
      q.iclass = agsc_pkg::IC_STACK;
      q.stk = agsc_pkg::SO_PUSH;
      for (i = 0; i < 3; i++)
      begin
         q.push_data = 16'hab00 + 16'(i);
         send(q);
         ck(rsp_o.dst_ea, 16'h0800 + 16'(2 * i), "push addr");
         cb(stack_trap_o, i == 2, "limit trap");
         cb(rsp_o.stack_err, i == 2, "stack error flag");
         cb(rsp_o.mem_we, 1'b1, "push write");
         if (i < 2) ck(stack_pointer_o, 16'h0802 + 16'(2 * i), "push sp");
      end
      ck(i_agsc_dmem_model.mem[1], 16'hab01, "pushed word");
      wr(4'hf, 16'h0802);
      q.stk = agsc_pkg::SO_POP;
      send(q);
      ck(rsp_o.src_ea, 16'h0800, "pop addr");
      cb(rsp_o.mem_re, 1'b1, "pop read");
      cb(rsp_o.valid, 1'b1, "pop response");
      cb(stack_trap_o, 1'b0, "pop ok");
      send(q);
      cb(stack_trap_o, 1'b1, "pop underflow");
      wr(4'hf, 16'h07fe);
      q.stk = agsc_pkg::SO_PUSH;
      send(q);
      cb(stack_trap_o, 1'b1, "push underflow");
      $display("test stack done");
   endtask
   task automatic t_pc();
      wr(4'hf, 16'h0900);
      wl(16'h0ffe);
      q = '0;
      q.iclass = agsc_pkg::IC_STACK;
      q.stk = agsc_pkg::SO_CALL;
      q.pc = 24'hff1234;
      q.status_low_byte = 8'h5a;
      send(q);
      ck(rsp_o.mem_wdata, 16'h007f, "call word");
      q.stk = agsc_pkg::SO_EXC;
      send(q);
      ck(rsp_o.mem_wdata, 16'h5a7f, "exception word");
      $display("test pc push done");
   endtask
   // mid-run reset: pointer back to the floor, limit and flags cleared
   task automatic t_reset();
      @(posedge core_clk_i);
      #1 sys_rst_i = 1'b1;
      @(posedge core_clk_i);
      #1 sys_rst_i = 1'b0;
      ck(stack_pointer_o, agsc_pkg::STACK_FLOOR, "reset pointer");
      ck(stack_limit_o, 16'h0000, "reset limit");
      cb(stack_trap_o, 1'b0, "reset trap");
      cb(rsp_o.valid, 1'b0, "reset response");
      $display("test reset done");
   endtask
   task automatic t_modes();
      int i;
      agsc_pkg::agsc_class_t c[7] = '{agsc_pkg::IC_MCU, agsc_pkg::IC_MCU, agsc_pkg::IC_MOVE,
         agsc_pkg::IC_MOVE, agsc_pkg::IC_MCU, agsc_pkg::IC_FILE, agsc_pkg::IC_MOVE};
      agsc_pkg::agsc_mode_t m[7] = '{agsc_pkg::AM_POST, agsc_pkg::AM_PRE, agsc_pkg::AM_INDEX,
         agsc_pkg::AM_LITOFS, agsc_pkg::AM_INDIR, agsc_pkg::AM_FILE, agsc_pkg::AM_FAR};
      logic [15:0] l[7] = '{16'h2, 16'hfffe, 16'h0, 16'h4, 16'h0, 16'h1ffe, 16'hc000};
      logic [15:0] ea[7] = '{16'h1000, 16'h1000, 16'h1010, 16'h1004, 16'h1000, 16'h1ffe, 16'hc000};
      wr(4'h1, 16'h1000);
      wr(4'h2, 16'h0010);
      for (i = 0; i < 7; i++)
      begin
         q = '0;
         q.iclass = c[i];
         q.src_mode = m[i];
         q.src_reg = 4'h1;
         q.ofs_reg = 4'h2;
         q.dst_reg = 4'h5;
         q.literal = l[i];
         send(q);
         ck(rsp_o.src_ea, ea[i], "mode address");
         cb(rsp_o.wb_en, i < 2, "writeback");
         if (i < 2) ck(rsp_o.wb_val, i == 0 ? 16'h1002 : 16'h1000, "updated ptr");
         if (i == 5) ck({12'h0, rsp_o.res_reg}, 16'h0, "default reg");
         if (i == 4) ck({12'h0, rsp_o.res_reg}, 16'h0005, "result reg");
         if (i == 0) ck({12'h0, rsp_o.wb_reg}, 16'h0001, "writeback reg");
      end
      q.src_mode = agsc_pkg::AM_INDEX;
      q.dst_mode = agsc_pkg::AM_INDEX;
      q.dst_reg = 4'h2;
      send(q);
      ck(rsp_o.src_ea, 16'h1010, "shared offset src");
      ck(rsp_o.dst_ea, 16'h0020, "shared offset dst");
      q.src_mode = agsc_pkg::AM_LIT;
      q.literal = 16'h12ab;
      q.byte_op = 1'b1;
      send(q);
      cb(rsp_o.src_is_lit, 1'b1, "literal source");
      ck(rsp_o.lit_val, 16'h00ab, "byte literal");
      q.byte_op = 1'b0;
      send(q);
      ck(rsp_o.lit_val, 16'h12ab, "word literal");
      q.iclass = agsc_pkg::IC_MCU;
      q.src_mode = agsc_pkg::AM_INDEX;
      send(q);
      cb(rsp_o.mode_err, 1'b1, "mcu indexed refused");
      $display("test modes done");
   endtask
   task automatic t_dsp();
      int r;
      q = '0;
      q.iclass = agsc_pkg::IC_DSP;
      q.src_mode = agsc_pkg::AM_POST;
      q.literal = 16'h6;
      for (r = 8; r < 12; r++)
      begin
         q.src_reg = 4'(r);
         send(q);
         cb(rsp_o.x_sel, r < 10, "x unit");
         cb(rsp_o.y_sel, r > 9, "y unit");
         cb(rsp_o.mode_err, 1'b0, "legal dsp mode");
      end
      q.src_mode = agsc_pkg::AM_LITOFS;
      send(q);
      cb(rsp_o.mode_err, 1'b1, "illegal dsp mode");
      cb(rsp_o.wb_en, 1'b0, "no writeback");
      q.src_mode = agsc_pkg::AM_POST;
      q.literal = 16'h8;
      send(q);
      cb(rsp_o.mode_err, 1'b1, "post by eight refused");
      cb(rsp_o.wb_en, 1'b0, "refused no writeback");
      q.literal = 16'h2;
      q.src_reg = 4'h7;
      send(q);
      cb(rsp_o.mode_err, 1'b1, "non prefetch register");
      $display("test dsp done");
   endtask
   task automatic t_sec();
      int i;
      wr(4'h3, 16'h0880);
      wr(4'h4, 16'h0980);
      q = '0;
      q.iclass = agsc_pkg::IC_MCU;
      q.src_mode = agsc_pkg::AM_INDIR;
      for (i = 0; i < 4; i++)
      begin
         q.src_reg = i > 1 ? 4'h4 : 4'h3;
         prot = {2'b11, i == 1, i == 3};
         send(q);
         cb(rsp_o.sec_err, i == 0 || i == 2, "secure gate");
      end
      $display("test secure done");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // generous: the whole sequence needs well under a thousand cycles
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (20) @(posedge core_clk_i);
      #1 sys_rst_i = 1'b0;
      t_stack();
      t_pc();
      t_reset();
      t_modes();
      t_dsp();
      t_sec();
      end_of_test();
   end
endmodule // agsc_top_tb

// [rtl/agsc_ea_unit.sv]
// effective address former for one operand
// assumes pointer and offset register values come from the register file
`timescale 1ns/100ps
module agsc_ea_unit
(
   input wire agsc_pkg::agsc_mode_t mode_i,
   input wire logic [15:0] ptr_i,
   input wire logic [15:0] ofs_i,
   input wire logic [15:0] lit_i,
   input wire logic byte_i,
   output logic [15:0] ea_o,
   output logic [15:0] upd_o,
   output logic upd_en_o
);
   logic [15:0] step;

   always_comb
   begin
      step = byte_i ? 16'h0001 : 16'h0002;
      ea_o = ptr_i;
      upd_o = ptr_i;
      upd_en_o = 1'b0;
      unique case (mode_i)
         agsc_pkg::AM_POST:
         begin
            ea_o = ptr_i;
            upd_o = ptr_i + lit_i;
            upd_en_o = 1'b1;
         end
         agsc_pkg::AM_PRE:
         begin
            ea_o = ptr_i + lit_i;
            upd_o = ptr_i + lit_i;
            upd_en_o = 1'b1;
         end
         agsc_pkg::AM_INDEX: ea_o = ptr_i + ofs_i;
         agsc_pkg::AM_LITOFS: ea_o = ptr_i + lit_i;
         agsc_pkg::AM_FILE: ea_o = lit_i & 16'h1fff;
         agsc_pkg::AM_FAR: ea_o = lit_i;
         default: ea_o = ptr_i;
      endcase
      if (step == 16'h0000)
         ea_o = 16'h0000;
   end
endmodule // agsc_ea_unit

// [rtl/agsc_pkg.sv]
// package for the address generation and stack check block
// assumes a 16-bit data space with byte addresses and a one-clock core
//
// Summary of operation
// - stack pointer names next free word, grows up
// - push writes then increments, pop decrements then reads
// - call push clears the counter top bit
// - exception push joins status byte onto counter
// - stack limit bit zero always zero
// - push past equal limit traps on next push
// - stack address below floor raises underflow trap
// - secure ram segments reachable only from own code
// - file register direct address spans near space
// - working register zero is default file destination
// - move direct address reaches whole data space
// - first source register direct, second varied
// - direct, indirect, post, pre and literal modes
// - address formed per mode from pointer and offset
// - move adds indexed, literal offset, byte/word literal
// - move source and destination share offset field
// - dsp prefetch pointers eight to eleven, split x/y
// - dsp modes indirect, post by 2/4/6, indexed
package agsc_pkg;
   localparam int DW = 16;
   localparam logic [15:0] STACK_FLOOR = 16'h0800;
   localparam logic [15:0] NEAR_LIMIT = 16'h2000;
   localparam logic [3:0] SP_IDX = 4'hf;
   localparam logic [3:0] DEFAULT_REG_IDX = 4'h0;
   localparam logic [3:0] XPF_A = 4'h8;
   localparam logic [3:0] XPF_B = 4'h9;
   localparam logic [3:0] YPF_A = 4'ha;
   localparam logic [3:0] YPF_B = 4'hb;
   localparam int LIMIT_LSB = 0;

   typedef enum logic [3:0] {
      AM_DIRECT = 4'h0, AM_INDIR = 4'h1, AM_POST = 4'h2, AM_PRE = 4'h3,
      AM_INDEX = 4'h4, AM_LITOFS = 4'h5, AM_LIT = 4'h6, AM_FILE = 4'h7,
      AM_FAR = 4'h8
   } agsc_mode_t;

   typedef enum logic [2:0] {
      IC_FILE = 3'h0, IC_MCU = 3'h1, IC_MOVE = 3'h2, IC_DSP = 3'h3, IC_STACK = 3'h4
   } agsc_class_t;

   typedef enum logic [2:0] {
      SO_NONE = 3'h0, SO_PUSH = 3'h1, SO_POP = 3'h2, SO_CALL = 3'h3, SO_EXC = 3'h4
   } agsc_stk_t;

   typedef struct packed {
      logic valid;
      agsc_class_t iclass;
      agsc_mode_t src_mode;
      agsc_mode_t dst_mode;
      logic [3:0] src_reg;
      logic [3:0] dst_reg;
      logic [3:0] ofs_reg;
      logic [15:0] literal;
      logic byte_op;
      logic dst_to_file;
      agsc_stk_t stk;
      logic [23:0] pc;
      logic [7:0] status_low_byte;
      logic [15:0] push_data;
   } agsc_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] src_ea;
      logic [15:0] dst_ea;
      logic [15:0] lit_val;
      logic src_is_lit;
      logic x_sel;
      logic y_sel;
      logic wb_en;
      logic [3:0] wb_reg;
      logic [15:0] wb_val;
      logic [3:0] res_reg;
      logic mem_we;
      logic [15:0] mem_wdata;
      logic mem_re;
      logic stack_err;
      logic sec_err;
      logic mode_err;
   } agsc_rsp_t;
endpackage

// [rtl/agsc_top.sv]
// address generation, stack checking and secure ram gating
// assumes the decoder presents one request per cycle; register file is held here
`timescale 1ns/100ps
module agsc_top
#(
   parameter logic [15:0] BOOT_RAM_LO = 16'h0800,
   parameter logic [15:0] BOOT_RAM_HI = 16'h08ff,
   parameter logic [15:0] SEC_RAM_LO = 16'h0900,
   parameter logic [15:0] SEC_RAM_HI = 16'h09ff
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire agsc_pkg::agsc_req_t req_i,
   input wire logic reg_we_i,
   input wire logic [3:0] reg_waddr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic stack_limit_reg_we_i,
   input wire logic [15:0] stack_limit_reg_wdata_i,
   input wire logic boot_prot_en_i,
   input wire logic sec_prot_en_i,
   input wire logic exec_boot_i,
   input wire logic exec_sec_i,
   output agsc_pkg::agsc_rsp_t rsp_o,
   output logic [15:0] stack_pointer_o,
   output logic [15:0] stack_limit_o,
   output logic stack_trap_o
);
   typedef struct packed {
      logic [15:0][15:0] default_working_reg;
      logic [15:0] stack_limit_reg;
      agsc_pkg::agsc_rsp_t rsp;
      logic trap;
   } agsc_state_t;

   agsc_state_t st_r;
   agsc_state_t st_nxt;
   logic [15:0] src_ea;
   logic [15:0] src_upd;
   logic src_upd_en;
   logic [15:0] dst_ea;
   logic [15:0] dst_upd;
   logic dst_upd_en;

   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic sec_block(input logic [15:0] a, input logic be, input logic se,
                                      input logic eb, input logic es);
      sec_block = (be && in_rng(a, BOOT_RAM_LO, BOOT_RAM_HI) && !eb)
               || (se && in_rng(a, SEC_RAM_LO, SEC_RAM_HI) && !es);
   endfunction

   agsc_ea_unit u_src
   (
      .mode_i(req_i.src_mode),
      .ptr_i(st_r.default_working_reg[req_i.src_reg]),
      .ofs_i(st_r.default_working_reg[req_i.ofs_reg]),
      .lit_i(req_i.literal),
      .byte_i(req_i.byte_op),
      .ea_o(src_ea),
      .upd_o(src_upd),
      .upd_en_o(src_upd_en)
   );

   agsc_ea_unit u_dst
   (
      .mode_i(req_i.dst_mode),
      .ptr_i(st_r.default_working_reg[req_i.dst_reg]),
      .ofs_i(st_r.default_working_reg[req_i.ofs_reg]),
      .lit_i(req_i.literal),
      .byte_i(req_i.byte_op),
      .ea_o(dst_ea),
      .upd_o(dst_upd),
      .upd_en_o(dst_upd_en)
   );

   always_comb
   begin
      logic [15:0] sp;
      logic [15:0] sp_new;
      logic mode_ok;
      logic uses_sp;
      sp = st_r.default_working_reg[agsc_pkg::SP_IDX];
      sp_new = sp;
      mode_ok = 1'b1;
      uses_sp = 1'b0;
      st_nxt = st_r;
      st_nxt.rsp = '0;
      st_nxt.trap = 1'b0;
      if (reg_we_i)
         st_nxt.default_working_reg[reg_waddr_i] = reg_wdata_i;
      if (stack_limit_reg_we_i)
         st_nxt.stack_limit_reg = {stack_limit_reg_wdata_i[15:1], 1'b0};
      if (req_i.valid)
      begin
         st_nxt.rsp.valid = 1'b1;
         st_nxt.rsp.src_ea = src_ea;
         st_nxt.rsp.dst_ea = dst_ea;
         st_nxt.rsp.res_reg = req_i.dst_to_file ? 4'h0 : req_i.dst_reg;
         unique case (req_i.iclass)
            agsc_pkg::IC_FILE:
            begin
               mode_ok = (req_i.src_mode == agsc_pkg::AM_FILE);
               if (!req_i.dst_to_file)
                  st_nxt.rsp.res_reg = agsc_pkg::DEFAULT_REG_IDX;
            end
            agsc_pkg::IC_MCU:
               mode_ok = (req_i.src_mode inside {agsc_pkg::AM_DIRECT, agsc_pkg::AM_INDIR,
                  agsc_pkg::AM_POST, agsc_pkg::AM_PRE, agsc_pkg::AM_LIT})
                  && (req_i.dst_mode != agsc_pkg::AM_LIT);
            agsc_pkg::IC_MOVE:
               mode_ok = (req_i.dst_mode != agsc_pkg::AM_LIT);
            agsc_pkg::IC_DSP:
            begin
               mode_ok = (req_i.src_reg inside {agsc_pkg::XPF_A, agsc_pkg::XPF_B,
                  agsc_pkg::YPF_A, agsc_pkg::YPF_B})
                  && ((req_i.src_mode == agsc_pkg::AM_INDIR)
                  || (req_i.src_mode == agsc_pkg::AM_INDEX)
                  || ((req_i.src_mode == agsc_pkg::AM_POST) && (req_i.literal inside
                     {16'h0002, 16'h0004, 16'h0006, 16'hfffe, 16'hfffc, 16'hfffa})));
               st_nxt.rsp.x_sel = !req_i.src_reg[1];
               st_nxt.rsp.y_sel = req_i.src_reg[1];
            end
            default: mode_ok = 1'b1;
         endcase
         st_nxt.rsp.src_is_lit = (req_i.src_mode == agsc_pkg::AM_LIT);
         st_nxt.rsp.lit_val = req_i.byte_op ? {8'h00, req_i.literal[7:0]} : req_i.literal;
         st_nxt.rsp.mode_err = !mode_ok;
         if (mode_ok && src_upd_en)
         begin
            st_nxt.rsp.wb_en = 1'b1;
            st_nxt.rsp.wb_reg = req_i.src_reg;
            st_nxt.rsp.wb_val = src_upd;
            st_nxt.default_working_reg[req_i.src_reg] = src_upd;
         end
         if (mode_ok && dst_upd_en)
         begin
            st_nxt.rsp.wb_en = 1'b1;
            st_nxt.rsp.wb_reg = req_i.dst_reg;
            st_nxt.rsp.wb_val = dst_upd;
            st_nxt.default_working_reg[req_i.dst_reg] = dst_upd;
         end
         unique case (req_i.stk)
            agsc_pkg::SO_PUSH, agsc_pkg::SO_CALL, agsc_pkg::SO_EXC:
            begin
               uses_sp = 1'b1;
               st_nxt.rsp.dst_ea = sp;
               st_nxt.rsp.mem_we = 1'b1;
               sp_new = sp + 16'h0002;
               unique case (req_i.stk)
                  agsc_pkg::SO_CALL:
                     st_nxt.rsp.mem_wdata = {9'h000, req_i.pc[22:16]};
                  agsc_pkg::SO_EXC:
                     st_nxt.rsp.mem_wdata = {req_i.status_low_byte, 1'b0,
                        req_i.pc[22:16]};
                  default: st_nxt.rsp.mem_wdata = req_i.push_data;
               endcase
               if (sp > st_r.stack_limit_reg)
                  st_nxt.trap = 1'b1;
            end
            agsc_pkg::SO_POP:
            begin
               uses_sp = 1'b1;
               sp_new = sp - 16'h0002;
               st_nxt.rsp.src_ea = sp_new;
               st_nxt.rsp.mem_re = 1'b1;
               if (sp_new > st_r.stack_limit_reg)
                  st_nxt.trap = 1'b1;
            end
            default: sp_new = sp;
         endcase
         if (req_i.src_reg == agsc_pkg::SP_IDX && req_i.src_mode != agsc_pkg::AM_DIRECT
             && src_ea > st_r.stack_limit_reg && req_i.src_mode != agsc_pkg::AM_LIT)
            st_nxt.trap = 1'b1;
         // destination pointer through the stack register is checked the same way
         if (req_i.dst_reg == agsc_pkg::SP_IDX && req_i.dst_mode != agsc_pkg::AM_DIRECT
             && dst_ea > st_r.stack_limit_reg && req_i.dst_mode != agsc_pkg::AM_LIT)
            st_nxt.trap = 1'b1;
         if (uses_sp)
         begin
            st_nxt.default_working_reg[agsc_pkg::SP_IDX] = sp_new;
            if (sp_new < agsc_pkg::STACK_FLOOR || sp < agsc_pkg::STACK_FLOOR)
               st_nxt.trap = 1'b1;
         end
         if (sec_block(st_nxt.rsp.src_ea, boot_prot_en_i, sec_prot_en_i, exec_boot_i,
                exec_sec_i) || sec_block(st_nxt.rsp.dst_ea, boot_prot_en_i,
                sec_prot_en_i, exec_boot_i, exec_sec_i))
         begin
            st_nxt.rsp.sec_err = 1'b1;
            st_nxt.rsp.mem_we = 1'b0;
            st_nxt.rsp.mem_re = 1'b0;
         end
         st_nxt.rsp.stack_err = st_nxt.trap;
      end
      st_nxt.default_working_reg[agsc_pkg::SP_IDX][0] = 1'b0;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= '0;
         st_r.default_working_reg[agsc_pkg::SP_IDX] <= agsc_pkg::STACK_FLOOR;
      end
      else
         st_r <= st_nxt;
   end

   assign rsp_o = st_r.rsp;
   assign stack_pointer_o = st_r.default_working_reg[agsc_pkg::SP_IDX];
   assign stack_limit_o = st_r.stack_limit_reg;
   assign stack_trap_o = st_r.trap;
endmodule // agsc_top
